// ---- hdl/fcs_sequencer.sv ----
// Flash command sequencer: command object, launch, erase/verify, security, emulation enable
//
// Function
// - Sector erase runs erase, then blank verify, then sets command complete.
// - Sector erase flags access error if index is not 1 at launch.
// - Erase, unsecure or enable-emulation during load-data-field sets access error.
// - A command not allowed in the current chip mode sets access error.
// - Sector erase with invalid block address bits sets access error.
// - Sector erase with address low three bits nonzero sets access error.
// - Protected sector sets protection violation; emulation-protect flag untouched.
// - Verify sets the verify-error bit when verify fails or the sector is not blank.
// - Verify sets the uncorrectable bit on an uncorrectable error.
// - Unsecure, code 0x0B: erase both arrays, verify, release security on success.
// - Failed unsecure verify sets verify-error bit and leaves security unchanged.
// - Emulation is off after reset until the 0x13 command runs.
// - Enable-emulation activates from tag RAM and counter, then sets complete.
// - Enable-emulation without prior partitioning sets access error.
// - Enable-emulation flags access error if index is not 0 at launch.
// - Security field value 10 means unsecured; all others secured.
// - Three-bit command index at offset 0x2 selects the command object word.
// - Index bits read/write; other bits of the register read zero.
// - ECC report index selects report word; only index bits writable.
// - Stop request waits until active command and pending emulation finish.
// - Security register loads from the configuration security byte in the first cycle after reset release.
`timescale 1ns/10ps
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int ERASE_CYC  = FCS_ERASE_CYC,
  parameter int VERIFY_CYC = FCS_VERIFY_CYC,
  parameter int EMU_CYC    = FCS_EMU_CYC
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire fcs_bus_req_t i_bus,
  output logic [7:0]       o_rdata,
  // Chip context
  input  wire logic        i_ldf_active,
  input  wire logic        i_mode_ok,
  input  wire logic [7:0]  i_blk_valid,
  input  wire logic [7:0]  i_blk_prot,
  input  wire logic [7:0]  i_cfg_sec_byte,
  input  wire logic        i_emu_pending,
  input  wire logic        i_stop_req,
  input  wire logic [15:0] i_ecc_word,
  // Array operation
  input  wire fcs_vfy_t    i_vfy,
  output logic             o_erase_sector,
  output logic             o_erase_all,
  output logic [6:0]       o_blk,
  output logic [15:0]      o_addr,
  output logic             o_verify,
  // Results
  output logic             o_emu_enabled,
  output logic             o_secure,
  output logic             o_stop_ack,
  output logic [2:0]       o_ecc_ix
);
  typedef struct packed {
    fcs_state_t  st;
    logic [15:0] obj0;
    logic [15:0] obj1;
    logic [2:0]  cix;
    logic [2:0]  eix;
    logic        command_complete_flag;
    logic        access_error_flag;
    logic        pviol;
    logic        vfy_err;
    logic        vfy_unc;
    logic        unsec_cmd;
    logic        emu_on;
    logic        part;
    logic [7:0]  sec;
    logic [15:0] cnt;
    logic [7:0]  rdata;
  } fcs_regs_t;

  fcs_regs_t r_r, r_nxt;
  logic      chk_acc;
  logic      chk_pv;
  logic      launch;

  fcs_launch_check u_chk (
    .i_cmd         (r_r.obj0[15:8]),
    .i_blk         (r_r.obj0[6:0]),
    .i_addr        (r_r.obj1),
    .i_ix          (r_r.cix),
    .i_ldf_active  (i_ldf_active),
    .i_mode_ok     (i_mode_ok),
    .i_blk_valid   (i_blk_valid),
    .i_blk_prot    (i_blk_prot),
    .i_partitioned (r_r.part),
    .o_access_error_flag      (chk_acc),
    .o_pviol       (chk_pv)
  );

  // Launch is a write of one to the complete flag while it is set
  assign launch = i_bus.we && (i_bus.addr == FCS_OFF_STAT) && i_bus.wdata[FCS_ST_COMMAND_COMPLETE_FLAG]
                  && r_r.command_complete_flag;

  always_comb
  begin
    r_nxt       = r_r;
    r_nxt.rdata = 8'h00;
    if (r_r.st == FCS_SECLD)
    begin
      r_nxt.sec = i_cfg_sec_byte;
      r_nxt.st  = FCS_IDLE;
      r_nxt.command_complete_flag = 1'b1;
    end
    else
    begin
      // Register writes; the object and index are frozen while a command runs
      if (i_bus.we)
        case (i_bus.addr)
          FCS_OFF_STAT:
          begin
            if (i_bus.wdata[FCS_ST_ACCESS_ERROR_FLAG]) r_nxt.access_error_flag = 1'b0;
            if (i_bus.wdata[FCS_ST_PVIOL])  r_nxt.pviol  = 1'b0;
          end
          FCS_OFF_CMDIX: if (r_r.command_complete_flag) r_nxt.cix = i_bus.wdata[2:0];
          FCS_OFF_ECCIX: r_nxt.eix = i_bus.wdata[2:0];
          FCS_OFF_CTRL:  if (i_bus.wdata[FCS_CT_PART]) r_nxt.part = 1'b1;
          FCS_OFF_OBJ_HI:
            if (r_r.command_complete_flag)
            begin
              if (r_r.cix == FCS_IX_WORD0) r_nxt.obj0[15:8] = i_bus.wdata;
              if (r_r.cix == FCS_IX_WORD1) r_nxt.obj1[15:8] = i_bus.wdata;
            end
          FCS_OFF_OBJ_LO:
            if (r_r.command_complete_flag)
            begin
              if (r_r.cix == FCS_IX_WORD0) r_nxt.obj0[7:0] = i_bus.wdata;
              if (r_r.cix == FCS_IX_WORD1) r_nxt.obj1[7:0] = i_bus.wdata;
            end
          default: ;
        endcase

      // Launch: errors stop the array and leave complete set
      if (launch && !r_r.access_error_flag && !r_r.pviol)
      begin
        r_nxt.vfy_err = 1'b0;
        r_nxt.vfy_unc = 1'b0;
        if (chk_acc || chk_pv)
        begin
          r_nxt.access_error_flag = chk_acc;
          r_nxt.pviol  = chk_pv;
        end
        else
        begin
          r_nxt.command_complete_flag = 1'b0;
          r_nxt.cnt  = 16'h0000;
          case (r_r.obj0[15:8])
            FCS_CMD_ERASE_SECT:
            begin
              r_nxt.st = FCS_ERASE;
              r_nxt.unsec_cmd = 1'b0;
            end
            FCS_CMD_UNSECURE:
            begin
              r_nxt.st = FCS_ERASE;
              r_nxt.unsec_cmd = 1'b1;
            end
            default: r_nxt.st = FCS_EMU;
          endcase
        end
      end

      case (r_r.st)
        FCS_ERASE:
        begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
          if (r_r.cnt == 16'(ERASE_CYC - 1))
          begin
            r_nxt.st  = FCS_VERIFY;
            r_nxt.cnt = 16'h0000;
          end
        end
        FCS_VERIFY:
        begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
          if (r_r.cnt == 16'(VERIFY_CYC - 1))
          begin
            r_nxt.st   = FCS_IDLE;
            r_nxt.command_complete_flag = 1'b1;
            if (!i_vfy.ok || !i_vfy.blank) r_nxt.vfy_err = 1'b1;
            if (i_vfy.uncorr) r_nxt.vfy_unc = 1'b1;
            if (r_r.unsec_cmd && i_vfy.ok && i_vfy.blank && !i_vfy.uncorr)
              r_nxt.sec = {r_r.sec[7:2], FCS_SEC_UNSECURED};
          end
        end
        FCS_EMU:
        begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
          if (r_r.cnt == 16'(EMU_CYC - 1))
          begin
            r_nxt.st     = FCS_IDLE;
            r_nxt.emu_on = 1'b1;
            r_nxt.command_complete_flag   = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Read data stands in the cycle after the strobe
    if (i_bus.re)
      case (i_bus.addr)
        FCS_OFF_STAT:
          r_nxt.rdata = {r_r.command_complete_flag, 1'b0, r_r.access_error_flag, r_r.pviol, 2'b00,
                         r_r.vfy_err, r_r.vfy_unc};
        FCS_OFF_ERRSTAT: r_nxt.rdata = 8'h00;  // emulation-protect flag never set here
        FCS_OFF_CMDIX:   r_nxt.rdata = {5'h00, r_r.cix};
        FCS_OFF_ECCIX:   r_nxt.rdata = {5'h00, r_r.eix};
        FCS_OFF_SEC:     r_nxt.rdata = r_r.sec;
        FCS_OFF_CTRL:    r_nxt.rdata = {6'h00, r_r.emu_on, r_r.part};
        FCS_OFF_OBJ_HI:  r_nxt.rdata = (r_r.cix == FCS_IX_WORD0) ? r_r.obj0[15:8] :
                                       (r_r.cix == FCS_IX_WORD1) ? r_r.obj1[15:8] : 8'h00;
        FCS_OFF_OBJ_LO:  r_nxt.rdata = (r_r.cix == FCS_IX_WORD0) ? r_r.obj0[7:0] :
                                       (r_r.cix == FCS_IX_WORD1) ? r_r.obj1[7:0] : 8'h00;
        FCS_OFF_ECCR_HI: r_nxt.rdata = i_ecc_word[15:8];
        FCS_OFF_ECCR_LO: r_nxt.rdata = i_ecc_word[7:0];
        default:         r_nxt.rdata = 8'h00;
      endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_r       <= '0;
      r_r.st    <= FCS_SECLD;  // Security byte is captured right after release
      r_r.sec   <= FCS_SEC_RESET;
    end
    else
      r_r <= r_nxt;
  end

  assign o_rdata        = r_r.rdata;
  assign o_erase_sector = (r_r.st == FCS_ERASE) && !r_r.unsec_cmd;
  assign o_erase_all    = (r_r.st == FCS_ERASE) && r_r.unsec_cmd;
  assign o_blk          = r_r.obj0[6:0];
  assign o_addr         = r_r.obj1;
  assign o_verify       = (r_r.st == FCS_VERIFY);
  assign o_emu_enabled  = r_r.emu_on;
  assign o_secure       = (r_r.sec[1:0] != FCS_SEC_UNSECURED);
  // Stop waits for both the command and any emulation work
  assign o_stop_ack     = i_stop_req && r_r.command_complete_flag && !i_emu_pending;
  assign o_ecc_ix       = r_r.eix;

  // Assertions
  property p_rdz;
    @(posedge i_clk) disable iff (i_rst)
      i_bus.re && i_bus.addr == FCS_OFF_CMDIX |=> o_rdata[7:3] == 5'h00;
  endproperty
  a_rdz: assert property (p_rdz) else $error("index reads nonzero high bits");

  property p_err_no_op;
    @(posedge i_clk) disable iff (i_rst)
      launch && !r_r.access_error_flag && !r_r.pviol && (chk_acc || chk_pv)
      |=> r_r.command_complete_flag && r_r.st == FCS_IDLE;
  endproperty
  a_err_no_op: assert property (p_err_no_op) else $error("op started despite error");

  // Security may only drop by the reset load or by a finished unsecure command
  property p_sec;
    @(posedge i_clk) disable iff (i_rst)
      $fell(o_secure)
      |-> $past(r_r.st == FCS_SECLD) || ($past(r_r.st == FCS_VERIFY) && r_r.unsec_cmd);
  endproperty
  a_sec: assert property (p_sec) else $error("security released wrongly");

  property p_ldf_err;
    @(posedge i_clk) disable iff (i_rst)
      launch && !r_r.access_error_flag && !r_r.pviol && i_ldf_active
      |=> r_r.access_error_flag && r_r.command_complete_flag;
  endproperty
  a_ldf_err: assert property (p_ldf_err) else $error("launch during data load accepted");

  property p_pviol;
    @(posedge i_clk) disable iff (i_rst)
      launch && !r_r.access_error_flag && !r_r.pviol && r_r.obj0[15:8] == FCS_CMD_ERASE_SECT
      && !chk_acc && i_blk_prot[r_r.obj0[2:0]] |=> r_r.pviol && !o_erase_sector;
  endproperty
  a_pviol: assert property (p_pviol) else $error("protected sector not refused");

  property p_vfy_unc;
    @(posedge i_clk) disable iff (i_rst)
      r_r.st == FCS_VERIFY && r_nxt.st == FCS_IDLE && i_vfy.uncorr
      |=> r_r.vfy_unc && r_r.vfy_err;
  endproperty
  a_vfy_unc: assert property (p_vfy_unc) else $error("uncorrectable not reported");

  property p_unsec_ok;
    @(posedge i_clk) disable iff (i_rst)
      r_r.st == FCS_VERIFY && r_nxt.st == FCS_IDLE && r_r.unsec_cmd
      && i_vfy.ok && i_vfy.blank && !i_vfy.uncorr |=> !o_secure && r_r.command_complete_flag;
  endproperty
  a_unsec_ok: assert property (p_unsec_ok) else $error("security not released");

  property p_emu_part;
    @(posedge i_clk) disable iff (i_rst)
      launch && !r_r.access_error_flag && !r_r.pviol && r_r.obj0[15:8] == FCS_CMD_ENABLE_EMU
      && !r_r.part |=> r_r.access_error_flag && r_r.st == FCS_IDLE;
  endproperty
  a_emu_part: assert property (p_emu_part) else $error("unpartitioned enable accepted");

  property p_erase_then_verify;
    @(posedge i_clk) disable iff (i_rst)
      r_r.st == FCS_ERASE && r_nxt.st == FCS_VERIFY |=> o_verify && !r_r.command_complete_flag;
  endproperty
  a_erase_then_verify: assert property (p_erase_then_verify) else $error("no verify");

  property p_stop;
    @(posedge i_clk) disable iff (i_rst)
      o_stop_ack |-> r_r.st == FCS_IDLE && !i_emu_pending;
  endproperty
  a_stop: assert property (p_stop) else $error("stop during operation");

  property p_unsec_fail;
    @(posedge i_clk) disable iff (i_rst)
      r_r.st == FCS_VERIFY && r_nxt.st == FCS_IDLE && r_r.unsec_cmd && !i_vfy.ok
      |=> r_r.vfy_err && $stable(r_r.sec);
  endproperty
  a_unsec_fail: assert property (p_unsec_fail) else $error("unsecure failure wrong");

  property p_emu_off;
    @(posedge i_clk) disable iff (i_rst)
      !$past(r_r.st == FCS_EMU) && !$past(r_r.emu_on) |-> !r_r.emu_on;
  endproperty
  a_emu_off: assert property (p_emu_off) else $error("emulation on early");

  property p_bad_ix;
    @(posedge i_clk) disable iff (i_rst)
      launch && !r_r.access_error_flag && !r_r.pviol && r_r.obj0[15:8] == FCS_CMD_ERASE_SECT
      && r_r.cix != 3'h1 |=> r_r.access_error_flag;
  endproperty
  a_bad_ix: assert property (p_bad_ix) else $error("bad index not flagged");

  c_erase: cover property (@(posedge i_clk) r_r.st == FCS_ERASE ##[1:100] r_r.command_complete_flag);
  c_unsec: cover property (@(posedge i_clk) o_erase_all ##[1:100] !o_secure);
  c_emu:   cover property (@(posedge i_clk) r_r.st == FCS_EMU ##[1:10] o_emu_enabled);
  c_err:   cover property (@(posedge i_clk) launch && (chk_acc || chk_pv));
endmodule

// ---- hdl/fcs_pkg.sv ----
// Package: register map, command codes, field layouts and timing for the command sequencer
package fcs_pkg;
  // Register indices on the plain register port (byte offsets)
  localparam logic [3:0] FCS_OFF_STAT    = 4'h0;
  localparam logic [3:0] FCS_OFF_ERRSTAT = 4'h1;
  localparam logic [3:0] FCS_OFF_CMDIX   = 4'h2;
  localparam logic [3:0] FCS_OFF_ECCIX   = 4'h3;
  localparam logic [3:0] FCS_OFF_SEC     = 4'h4;
  localparam logic [3:0] FCS_OFF_CTRL    = 4'h5;
  localparam logic [3:0] FCS_OFF_OBJ_HI  = 4'h6;
  localparam logic [3:0] FCS_OFF_OBJ_LO  = 4'h7;
  localparam logic [3:0] FCS_OFF_ECCR_HI = 4'h8;
  localparam logic [3:0] FCS_OFF_ECCR_LO = 4'h9;

  // Status register bit positions
  localparam int FCS_ST_COMMAND_COMPLETE_FLAG    = 7;
  localparam int FCS_ST_ACCESS_ERROR_FLAG  = 5;
  localparam int FCS_ST_PVIOL   = 4;
  localparam int FCS_ST_MGBUSY  = 3;
  localparam int FCS_ST_VFYERR  = 1;
  localparam int FCS_ST_VFYUNC  = 0;
  localparam int FCS_ERR_EPVIOL = 4;
  // Control register bit positions
  localparam int FCS_CT_PART    = 0;
  localparam int FCS_CT_EMUON   = 1;

  // Command codes in word 0 high byte
  localparam logic [7:0] FCS_CMD_ERASE_SECT = 8'h0A;
  localparam logic [7:0] FCS_CMD_UNSECURE   = 8'h0B;
  localparam logic [7:0] FCS_CMD_ENABLE_EMU = 8'h13;

  localparam logic [2:0] FCS_IX_WORD0 = 3'h0;
  localparam logic [2:0] FCS_IX_WORD1 = 3'h1;
  localparam logic [2:0] FCS_PHRASE_LSB = 3'h0;

  // Security field
  localparam logic [1:0] FCS_SEC_UNSECURED = 2'h2;
  localparam logic [1:0] FCS_SEC_SECURED   = 2'h1;
  localparam logic [7:0] FCS_SEC_RESET     = 8'h01;

  // Array operation durations, kept short; the array model decides real time
  localparam int FCS_ERASE_NS  = 1000;
  localparam int FCS_VERIFY_NS = 500;
  localparam int FCS_CLK_NS    = 50;
  localparam int FCS_ERASE_CYC  = (FCS_ERASE_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_VERIFY_CYC = (FCS_VERIFY_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_EMU_CYC    = 4;

  typedef enum logic [2:0] {
    FCS_IDLE   = 3'h0,
    FCS_ERASE  = 3'h1,
    FCS_VERIFY = 3'h3,
    FCS_EMU    = 3'h2,
    FCS_SECLD  = 3'h6
  } fcs_state_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fcs_bus_req_t;

  typedef struct packed {
    logic       ok;
    logic       blank;
    logic       uncorr;
  } fcs_vfy_t;
endpackage

// ---- hdl/fcs_launch_check.sv ----
// Launch-time error checks for one command object
`timescale 1ns/10ps
module fcs_launch_check
  import fcs_pkg::*;
(
  // Command object
  input  wire logic [7:0]  i_cmd,
  input  wire logic [6:0]  i_blk,
  input  wire logic [15:0] i_addr,
  input  wire logic [2:0]  i_ix,
  // Context
  input  wire logic        i_ldf_active,
  input  wire logic        i_mode_ok,
  input  wire logic [7:0]  i_blk_valid,
  input  wire logic [7:0]  i_blk_prot,
  input  wire logic        i_partitioned,
  // Result
  output logic             o_access_error_flag,
  output logic             o_pviol
);
  always_comb
  begin
    o_access_error_flag = i_ldf_active || !i_mode_ok;
    o_pviol  = 1'b0;
    case (i_cmd)
      FCS_CMD_ERASE_SECT:
      begin
        if (i_ix != FCS_IX_WORD1) o_access_error_flag = 1'b1;
        if ((i_blk[6:3] != 4'h0) || !i_blk_valid[i_blk[2:0]]) o_access_error_flag = 1'b1;
        if (i_addr[2:0] != FCS_PHRASE_LSB) o_access_error_flag = 1'b1;
        if (!o_access_error_flag && i_blk_prot[i_blk[2:0]]) o_pviol = 1'b1;
      end
      FCS_CMD_UNSECURE:
        if (i_ix != FCS_IX_WORD0) o_access_error_flag = 1'b1;
      FCS_CMD_ENABLE_EMU:
      begin
        if (i_ix != FCS_IX_WORD0) o_access_error_flag = 1'b1;
        if (!i_partitioned) o_access_error_flag = 1'b1;
      end
      default: o_access_error_flag = 1'b1;
    endcase
  end
endmodule

// ---- bench/test_flash_command_sequencer.sv ----
// Self-checking register-level testbench for the flash command sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("FAIL %s expected %0h got %0h", nm, e, g); \
    end \
  end
module test_flash_command_sequencer
  import fcs_pkg::*;
;
  logic         i_clk = 1'b0;
  logic         i_rst = 1'b1;
  fcs_bus_req_t bus = '0;
  logic         ldf = 1'b0;
  logic         mode_ok = 1'b1;
  logic [7:0]   cfg_sec = 8'hFE;
  logic         emu_pend = 1'b0;
  logic         stop_req = 1'b0;
  logic [15:0]  ecc_word = 16'hA55A;
  fcs_vfy_t     vfy = 3'h6;
  logic [7:0]   o_rdata;
  logic         o_erase_sector;
  logic         o_erase_all;
  logic [6:0]   o_blk;
  logic [15:0]  o_addr;
  logic         o_verify;
  logic         o_emu_enabled;
  logic         o_secure;
  logic         o_stop_ack;
  logic [2:0]   o_ecc_ix;
  int           err_total = 0;
  int           cmp_count = 0;
  logic [7:0]   d;
  int           n;

  // Short array phases keep the run small; counts below follow these values
  fcs_sequencer #(.ERASE_CYC(20), .VERIFY_CYC(10), .EMU_CYC(4)) i_dut (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_bus          (bus),
    .o_rdata        (o_rdata),
    .i_ldf_active   (ldf),
    .i_mode_ok      (mode_ok),
    .i_blk_valid    (8'h0F),
    .i_blk_prot     (8'h04),
    .i_cfg_sec_byte (cfg_sec),
    .i_emu_pending  (emu_pend),
    .i_stop_req     (stop_req),
    .i_ecc_word     (ecc_word),
    .i_vfy          (vfy),
    .o_erase_sector (o_erase_sector),
    .o_erase_all    (o_erase_all),
    .o_blk          (o_blk),
    .o_addr         (o_addr),
    .o_verify       (o_verify),
    .o_emu_enabled  (o_emu_enabled),
    .o_secure       (o_secure),
    .o_stop_ack     (o_stop_ack),
    .o_ecc_ix       (o_ecc_ix)
  );

  always #25 i_clk = ~i_clk;

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    bus <= {1'b1, 1'b0, a, v};
    @(posedge i_clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the taking edge
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk);
    bus <= '0;
    #1;
    v = o_rdata;
  endtask

  task automatic do_reset(input logic [7:0] b);
    @(posedge i_clk);
    cfg_sec <= b;
    i_rst   <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic load(input logic [7:0] c, input logic [6:0] b, input logic [15:0] a,
                      input logic [2:0] ix);
    wr(FCS_OFF_CMDIX, 8'h00);
    wr(FCS_OFF_OBJ_HI, c);
    wr(FCS_OFF_OBJ_LO, {1'b0, b});
    wr(FCS_OFF_CMDIX, 8'h01);
    wr(FCS_OFF_OBJ_HI, a[15:8]);
    wr(FCS_OFF_OBJ_LO, a[7:0]);
    wr(FCS_OFF_CMDIX, {5'h00, ix});
    wr(FCS_OFF_STAT, 8'h80);
    #1;
  endtask

  task automatic wait_done();
    n = 0;
    d = 8'h00;
    while (d[7] !== 1'b1 && n < 200)
    begin
      rd(FCS_OFF_STAT, d);
      n++;
    end
    `CHK("completion within bound", 1'b1, d[7])
  endtask

  // A refused launch must flag, leave the array idle, and clear on write-one
  task automatic err_case(input logic [7:0] c, input logic [6:0] b, input logic [15:0] a,
                          input logic [2:0] ix, input logic l, input logic m,
                          input logic [7:0] e);
    @(posedge i_clk);
    ldf     <= l;
    mode_ok <= m;
    load(c, b, a, ix);
    `CHK("array idle", 1'b0, o_erase_sector | o_erase_all)
    rd(FCS_OFF_STAT, d);
    `CHK("launch status", e, d)
    rd(FCS_OFF_ERRSTAT, d);
    `CHK("error status", 8'h00, d)
    @(posedge i_clk);
    ldf     <= 1'b0;
    mode_ok <= 1'b1;
    wr(FCS_OFF_STAT, 8'h30);
    rd(FCS_OFF_STAT, d);
    `CHK("flags cleared", 8'h80, d)
  endtask

  task automatic erase_run(input fcs_vfy_t v, input logic [7:0] e);
    @(posedge i_clk);
    vfy <= v;
    load(FCS_CMD_ERASE_SECT, 7'h01, 16'h1238, 3'h1);
    `CHK("erase sector", 1'b1, o_erase_sector)
    `CHK("block", 7'h01, o_blk)
    `CHK("address", 16'h1238, o_addr)
    `CHK("stop held off", 1'b0, o_stop_ack)
    n = 0;
    while (o_erase_sector === 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK("erase cycles", 20, n)
    n = 0;
    while (o_verify === 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK("verify cycles", 10, n)
    rd(FCS_OFF_STAT, d);
    `CHK("erase status", e, d)
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    stop_test();
  end

  initial
  begin
    do_reset(8'hFE);
    rd(FCS_OFF_SEC, d);
    `CHK("security load", 8'hFE, d)
    rd(FCS_OFF_STAT, d);
    `CHK("idle status", 8'h80, d)
    `CHK("emulation off", 1'b0, o_emu_enabled)
    wr(FCS_OFF_CMDIX, 8'hFF);
    rd(FCS_OFF_CMDIX, d);
    `CHK("command index", 8'h07, d)
    wr(FCS_OFF_ECCIX, 8'hF8);
    rd(FCS_OFF_ECCIX, d);
    `CHK("ecc index", 8'h00, d)
    `CHK("ecc index port", 3'h0, o_ecc_ix)
    rd(FCS_OFF_ECCR_HI, d);
    `CHK("ecc word hi", 8'hA5, d)
    rd(FCS_OFF_ECCR_LO, d);
    `CHK("ecc word lo", 8'h5A, d)
    rd(4'hF, d);
    `CHK("unmapped", 8'h00, d)
    wr(FCS_OFF_CMDIX, 8'h00);
    wr(FCS_OFF_OBJ_HI, 8'h0A);
    rd(FCS_OFF_OBJ_HI, d);
    `CHK("object word", 8'h0A, d)
    err_case(8'h0A, 7'h01, 16'h1238, 3'h0, 1'b0, 1'b1, 8'hA0);
    err_case(8'h0A, 7'h01, 16'h1238, 3'h1, 1'b1, 1'b1, 8'hA0);
    err_case(8'h0B, 7'h00, 16'h0000, 3'h0, 1'b1, 1'b1, 8'hA0);
    err_case(8'h13, 7'h00, 16'h0000, 3'h0, 1'b1, 1'b1, 8'hA0);
    err_case(8'h0A, 7'h01, 16'h1238, 3'h1, 1'b0, 1'b0, 8'hA0);
    err_case(8'h0A, 7'h08, 16'h1238, 3'h1, 1'b0, 1'b1, 8'hA0);
    err_case(8'h0A, 7'h05, 16'h1238, 3'h1, 1'b0, 1'b1, 8'hA0);
    err_case(8'h0A, 7'h01, 16'h123C, 3'h1, 1'b0, 1'b1, 8'hA0);
    err_case(8'h0A, 7'h02, 16'h1238, 3'h1, 1'b0, 1'b1, 8'h90);
    err_case(8'h13, 7'h00, 16'h0000, 3'h0, 1'b0, 1'b1, 8'hA0);
    @(posedge i_clk);
    stop_req <= 1'b1;
    erase_run(3'h6, 8'h80);
    `CHK("stop granted", 1'b1, o_stop_ack)
    @(posedge i_clk);
    emu_pend <= 1'b1;
    @(posedge i_clk);
    #1;
    `CHK("stop waits emulation", 1'b0, o_stop_ack)
    @(posedge i_clk);
    emu_pend <= 1'b0;
    stop_req <= 1'b0;
    erase_run(3'h0, 8'h82);
    erase_run(3'h1, 8'h83);
    wr(FCS_OFF_CTRL, 8'h01);
    err_case(8'h13, 7'h00, 16'h0000, 3'h1, 1'b0, 1'b1, 8'hA0);
    load(FCS_CMD_ENABLE_EMU, 7'h00, 16'h0000, 3'h0);
    wait_done();
    `CHK("emulation on", 1'b1, o_emu_enabled)
    rd(FCS_OFF_CTRL, d);
    `CHK("control", 8'h03, d)
    for (int s = 0; s < 4; s++)
    begin
      do_reset({6'h29, s[1:0]});
      `CHK("secure decode", (s != 2), o_secure)
      `CHK("emulation off after reset", 1'b0, o_emu_enabled)
    end
    do_reset(8'h01);
    @(posedge i_clk);
    vfy <= 3'h0;
    load(FCS_CMD_UNSECURE, 7'h00, 16'h0000, 3'h0);
    `CHK("erase all", 1'b1, o_erase_all)
    wait_done();
    `CHK("failed unsecure status", 8'h82, d)
    rd(FCS_OFF_SEC, d);
    `CHK("security kept", 8'h01, d)
    @(posedge i_clk);
    vfy <= 3'h6;
    load(FCS_CMD_UNSECURE, 7'h00, 16'h0000, 3'h0);
    wait_done();
    `CHK("unsecure status", 8'h80, d)
    `CHK("released", 1'b0, o_secure)
    rd(FCS_OFF_SEC, d);
    `CHK("security field", 2'h2, d[1:0])
    stop_test();
  end
endmodule
